// ### src/sfl_pkg.sv
// sfl_pkg: constants and carrier types for the serial flash link timing block
// assumes a 250 MHz core clock; all counts but the busy lag are derived from it here, which uses CLK_PERIOD_NS
package sfl_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  // times in their own units, as printed
  localparam int unsigned XFR_STD_US     = 250;
  localparam int unsigned XFR_LOW_US     = 300;
  localparam int unsigned EP_MS          = 20;
  localparam int unsigned BSY_LAG_NS     = 200;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  // cycle counts (the shortest time, the busy lag, rounds down)
  localparam int unsigned XFR_STD_CYC    = XFR_STD_US * CLK_MHZ;
  localparam int unsigned XFR_LOW_CYC    = XFR_LOW_US * CLK_MHZ;
  localparam int unsigned EP_CYC         = EP_MS * 1000 * CLK_MHZ;
  localparam int unsigned BSY_LAG_CYC    = BSY_LAG_NS / CLK_PERIOD_NS;
  localparam int unsigned BITS_PER_BYTE  = 8;
  localparam int unsigned ADDR_BYTES     = 3;
  localparam int unsigned CNT_W          = 24;
  // opcodes of self-timed commands
  localparam logic [7:0] OP_XFR_B1       = 8'h53;
  localparam logic [7:0] OP_XFR_B2       = 8'h55;
  localparam logic [7:0] OP_CMP_B1       = 8'h60;
  localparam logic [7:0] OP_CMP_B2       = 8'h61;
  localparam logic [7:0] OP_EP_B1        = 8'h83;
  localparam logic [7:0] OP_EP_B2        = 8'h86;
  localparam logic [7:0] OP_RW_B1        = 8'h58;
  localparam logic [7:0] OP_RW_B2        = 8'h59;
  // address field positions inside the 24 address bits
  localparam int unsigned RSV_MSB        = 23;
  localparam int unsigned RSV_LSB        = 20;
  localparam int unsigned PAGE_MSB       = 19;
  localparam int unsigned PAGE_LSB       = 9;

  typedef enum logic [1:0] {SFL_MODE0, SFL_MODE3} sfl_mode_t;

  // a decoded command leaving the shifter
  typedef struct packed {
    logic [7:0]  opcode;
    logic [10:0] page;
    logic [3:0]  reserved;
    sfl_mode_t   mode;
  } sfl_cmd_t;
endpackage

// ### src/sfl_sync.sv
// sfl_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clock; output follows after two agreeing samples
`timescale 1ns/1ps
module sfl_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic init,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // ===========================================
  // sample chain; s1 only feeds s2 to stay metastability safe
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1    <= init;
      s2    <= init;
      s3    <= init;
      level <= init;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule

// ### src/sfl_link.sv
// sfl_link: serial command front end and self-timed busy sequencer
// assumes cs_n, sck, si, reset_n are pins sampled by the 250 MHz clock;
// assumes the host keeps its own power-up, reset and spacing obligations
`timescale 1ns/1ps
// ===========================================
// frame and timing notes
// a frame is one opcode byte and three address bytes, msb first: 32 sck rises
// a frame of any other length raises no cmd_valid and launches nothing, though last_cmd and rsv_nonzero still take its bits
// each pin passes a three-stage sync, so a pin edge is seen about five clocks late;
// that spends about 20 ns of the 200 ns busy budget
// sck high and low phases need two clocks or more each, or edges merge and bits are lost
// the busy timer is a down counter, one count per clock, loaded at the select rise
// the reset pin wins over every state, a running busy period included
// reserved address bits are kept and flagged, never used to address anything
module sfl_link #(
  parameter int unsigned XFR_CYCLES = sfl_pkg::XFR_STD_CYC,
  parameter int unsigned EP_CYCLES  = sfl_pkg::EP_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       reset_n,
  output logic            rdy_busy_n,
  output sfl_pkg::sfl_cmd_t last_cmd,
  output logic            cmd_valid,
  output logic            rsv_nonzero
);
  typedef enum logic [1:0] {SFL_IDLE, SFL_SHIFT, SFL_BUSY} sfl_state_t;

  // ===========================================
  // internal state
  // filtered pin levels and their one-clock delays for edge finding
  logic                   cs_q;
  logic                   sck_q;
  logic                   si_q;
  logic                   rst_pin_q;
  logic                   cs_d;
  logic                   sck_d;
  // frame counters and shift path
  sfl_state_t             state;
  sfl_state_t             next_state;
  logic [2:0]             bit_cnt;
  logic [2:0]             next_bit_cnt;
  logic [2:0]             byte_cnt;
  logic [2:0]             next_byte_cnt;
  logic [7:0]             shreg;
  logic [7:0]             next_shreg;
  logic [23:0]            addr;
  logic [23:0]            next_addr;
  sfl_pkg::sfl_cmd_t      next_cmd;
  logic                   next_valid;
  logic                   next_rsv;
  // busy timer, loaded at the select rise and counted down once a clock
  logic [sfl_pkg::CNT_W-1:0] timer;
  logic [sfl_pkg::CNT_W-1:0] next_timer;
  logic                   next_busy_n;
  logic                   sck_rise;
  logic                   cs_fall;
  logic                   cs_rise;

  // ===========================================
  // pin synchronisers
  // init values match the idle pins: select high, clock low, reset asserted
  sfl_sync u_cs  (.clock(clock), .rst_n(rst_n), .pin(cs_n),    .init(1'b1), .level(cs_q));
  sfl_sync u_sck (.clock(clock), .rst_n(rst_n), .pin(sck),     .init(1'b0), .level(sck_q));
  sfl_sync u_si  (.clock(clock), .rst_n(rst_n), .pin(si),      .init(1'b0), .level(si_q));
  sfl_sync u_rst (.clock(clock), .rst_n(rst_n), .pin(reset_n), .init(1'b0), .level(rst_pin_q));

  // edge detection on filtered levels
  // sck_d starts low, the idle level of sck, so reset gives no false rise
  assign sck_rise = sck_q && !sck_d;
  assign cs_fall  = !cs_q && cs_d;
  assign cs_rise  = cs_q && !cs_d;

  // self-timed opcodes and their durations
  function automatic logic is_timed(input logic [7:0] op);
    is_timed = (op == sfl_pkg::OP_XFR_B1) || (op == sfl_pkg::OP_XFR_B2) ||
               (op == sfl_pkg::OP_CMP_B1) || (op == sfl_pkg::OP_CMP_B2) ||
               (op == sfl_pkg::OP_EP_B1)  || (op == sfl_pkg::OP_EP_B2)  ||
               (op == sfl_pkg::OP_RW_B1)  || (op == sfl_pkg::OP_RW_B2);
  endfunction

  // the low-voltage transfer time is had by setting XFR_CYCLES at the instance
  function automatic logic [sfl_pkg::CNT_W-1:0] op_cycles(input logic [7:0] op);
    if ((op == sfl_pkg::OP_XFR_B1) || (op == sfl_pkg::OP_XFR_B2) ||
        (op == sfl_pkg::OP_CMP_B1) || (op == sfl_pkg::OP_CMP_B2)) begin
      op_cycles = sfl_pkg::CNT_W'(XFR_CYCLES);
    end else begin
      op_cycles = sfl_pkg::CNT_W'(EP_CYCLES);
    end
  endfunction

  // ===========================================
  // command framing and busy sequencer
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shreg    = shreg;
    next_addr     = addr;
    next_cmd      = last_cmd;
    next_valid    = 1'b0;
    next_rsv      = rsv_nonzero;
    next_timer    = timer;
    next_busy_n   = rdy_busy_n;
    case (state)
      SFL_IDLE: begin
        if (cs_fall) begin
          // idle sck level at select fall picks the mode; both are legal
          next_cmd.mode = sck_q ? sfl_pkg::SFL_MODE3 : sfl_pkg::SFL_MODE0;
          // counters restart here, so a cut frame leaves no count behind
          next_bit_cnt  = 3'd0;
          next_byte_cnt = 3'd0;
          next_state    = SFL_SHIFT;
        end
      end
      SFL_SHIFT: begin
        if (sck_rise) begin
          next_shreg   = {shreg[6:0], si_q};
          next_bit_cnt = bit_cnt + 3'd1;
          if (bit_cnt == 3'(sfl_pkg::BITS_PER_BYTE - 1)) begin
            if (byte_cnt == 3'd0) begin
              next_cmd.opcode = {shreg[6:0], si_q};
            end else if (byte_cnt <= 3'(sfl_pkg::ADDR_BYTES)) begin
              next_addr = {addr[15:0], shreg[6:0], si_q};
            end
            // byte_cnt sticks at seven so a runaway frame never wraps to a valid count
            if (byte_cnt != 3'd7) begin
              next_byte_cnt = byte_cnt + 3'd1;
            end
          end
        end
        if (cs_rise) begin
          next_cmd.page     = addr[sfl_pkg::PAGE_MSB:sfl_pkg::PAGE_LSB];
          next_cmd.reserved = addr[sfl_pkg::RSV_MSB:sfl_pkg::RSV_LSB];
          // reserved bits are kept in last_cmd and flagged, never used to address anything
          next_rsv   = (addr[sfl_pkg::RSV_MSB:sfl_pkg::RSV_LSB] != 4'h0);
          next_valid = (byte_cnt == 3'(sfl_pkg::ADDR_BYTES + 1)) && (bit_cnt == 3'd0);
          if (is_timed(last_cmd.opcode) && next_valid) begin
            next_busy_n = 1'b0;
            next_timer  = op_cycles(last_cmd.opcode);
            next_state  = SFL_BUSY;
          end else begin
            next_state = SFL_IDLE;
          end
        end
      end
      SFL_BUSY: begin
        // selects during busy are ignored; the link stays silent
        // a command sent during busy is lost and the host must send it again
        if (timer <= sfl_pkg::CNT_W'(1)) begin
          next_busy_n = 1'b1;
          next_state  = SFL_IDLE;
        end else begin
          next_timer = timer - sfl_pkg::CNT_W'(1);
        end
      end
      default: begin
        next_state = SFL_IDLE;
      end
    endcase
    // the reset pin aborts everything; host holds select high first
    if (!rst_pin_q) begin
      next_state  = SFL_IDLE;
      next_busy_n = 1'b1;
      next_timer  = '0;
      next_valid  = 1'b0;
    end
  end

  // ===========================================
  // state registers
  // the reset pin is handled in the next-state logic; rst_n alone clears here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_d        <= 1'b1;
      sck_d       <= 1'b0;
      state       <= SFL_IDLE;
      bit_cnt     <= 3'd0;
      byte_cnt    <= 3'd0;
      shreg       <= 8'h00;
      addr        <= 24'h00_0000;
      last_cmd    <= '0;
      cmd_valid   <= 1'b0;
      rsv_nonzero <= 1'b0;
      timer       <= '0;
      rdy_busy_n  <= 1'b1;
    end else begin
      cs_d        <= cs_q;
      sck_d       <= sck_q;
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      byte_cnt    <= next_byte_cnt;
      shreg       <= next_shreg;
      addr        <= next_addr;
      last_cmd    <= next_cmd;
      cmd_valid   <= next_valid;
      rsv_nonzero <= next_rsv;
      timer       <= next_timer;
      rdy_busy_n  <= next_busy_n;
    end
  end
endmodule

// ### test/sfl_chk.sv
// sfl_chk: port checks for the serial flash link
// assumes clean pin edges between clock edges
`timescale 1ns/1ps
module sfl_chk #(
  parameter int unsigned XFR_CYCLES = 50,
  parameter int unsigned EP_CYCLES  = 200
) (
  input wire logic         clock,
  input wire logic         rst_n,
  input wire logic         cs_n,
  input wire logic         sck,
  input wire logic         si,
  input wire logic         reset_n,
  input wire logic         rdy_busy_n,
  input sfl_pkg::sfl_cmd_t last_cmd,
  input wire logic         cmd_valid,
  input wire logic         rsv_nonzero
);
  // ==========
  // pin shadow
  logic [31:0] sh;
  logic [5:0]  nb;
  logic [23:0] bc;
  logic [23:0] hc;
  logic        sq;
  logic        md;
  logic        ab;
  wire         xop = last_cmd.opcode inside {8'h53, 8'h55, 8'h60, 8'h61};
  wire         eop = last_cmd.opcode inside {8'h83, 8'h86, 8'h58, 8'h59};
  // ab: a pin reset cuts the busy time short, so skip length checks
  always_ff @(posedge clock) begin
    sq <= sck;
    if (!cs_n && sck && !sq) begin
      sh <= {sh[30:0], si};
      nb <= nb + 6'h1;
    end
    if ($fell(cs_n)) begin
      nb <= '0;
      md <= sck;
    end
    bc <= rdy_busy_n ? '0 : bc + 24'h1;
    hc <= cs_n ? hc + 24'h1 : '0;
    ab <= !reset_n || !rst_n || (ab && !cmd_valid);
  end
  // ==========
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    cmd_valid ##0 !rdy_busy_n;
  endsequence
  sequence s_hold;
    !rdy_busy_n [*2];
  endsequence
  property p_go; cmd_valid |-> s_start ##1 s_hold; endproperty
  a_go: assert property (p_go) else $error("busy not raised by command");
  property p_xfr; $rose(rdy_busy_n) && !ab && xop |-> bc == XFR_CYCLES; endproperty
  a_xfr: assert property (p_xfr) else $error("transfer busy length");
  property p_ep; $rose(rdy_busy_n) && !ab && eop |-> bc == EP_CYCLES; endproperty
  a_ep: assert property (p_ep) else $error("erase program busy length");
  property p_lag; cmd_valid |-> hc <= sfl_pkg::BSY_LAG_CYC; endproperty
  a_lag: assert property (p_lag) else $error("busy too late");
  property p_bits; cmd_valid |-> nb == 6'h20; endproperty
  a_bits: assert property (p_bits) else $error("frame not 32 bits");
  property p_cap; cmd_valid |-> {last_cmd.opcode, last_cmd.page} == {sh[31:24], sh[19:9]};
  endproperty
  a_cap: assert property (p_cap) else $error("captured bits wrong");
  property p_mode; cmd_valid |-> last_cmd.mode == {1'b0, md}; endproperty
  a_mode: assert property (p_mode) else $error("clock mode wrong");
  property p_one; cmd_valid |=> !cmd_valid; endproperty
  a_one: assert property (p_one) else $error("command pulse too long");
  property p_rsv; cmd_valid |-> rsv_nonzero == (|last_cmd.reserved); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
endmodule
bind sfl_link sfl_chk #(.XFR_CYCLES(XFR_CYCLES), .EP_CYCLES(EP_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .reset_n(reset_n),
  .rdy_busy_n(rdy_busy_n), .last_cmd(last_cmd), .cmd_valid(cmd_valid),
  .rsv_nonzero(rsv_nonzero));

// ### test/sfl_host.sv
// sfl_host: host serial controller model, msb first
// assumes a 250 MHz clock; sck period is 40 cycles (160 ns)
`timescale 1ns/1ps
module sfl_host (
  input  wire logic clock,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic w(int n);
    repeat (n) @(negedge clock);
  endtask
  // ==========
  // one frame of n bits; hi is the resting clock level
  // frames end after n bits, at most 33 in this bench, so no page boundary is ever crossed
  task automatic xfer(logic [31:0] d, int n, logic hi);
    sck <= hi;
    w(64); // gap of 256 ns between commands
    cs_n <= 1'b0;
    w(64);
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      si <= d[31];
      d = d << 1;
      w(20); // half of a 160 ns sck period, below the read clock limits
      sck <= 1'b1;
      w(20);
    end
    sck <= hi;
    w(64);
    cs_n <= 1'b1;
    si <= ~si; // released line must not look stale
  endtask
endmodule

// ### test/sfl_link_tb_top.sv
// sfl_link_tb_top: directed bench for the serial flash link
// assumes sfl_host drives the pins and sfl_chk is bound
`timescale 1ns/1ps
module sfl_link_tb_top;
  localparam int unsigned XC = 50;
  localparam int unsigned EC = 3000;
  localparam logic [7:0] OPS [8] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h83, 8'h86, 8'h58, 8'h59};
  logic              clock;
  logic              rst_n;
  logic              reset_n;
  logic              rdy_busy_n;
  logic              cmd_valid;
  logic              rsv_nonzero;
  sfl_pkg::sfl_cmd_t last_cmd;
  wire               cs_n;
  wire               sck;
  wire               si;
  int                n_errors;
  int                checks_done;
  // ==========
  // clock and instances
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  sfl_host u_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));
  sfl_link #(.XFR_CYCLES(XC), .EP_CYCLES(EC)) i_sfl_link (
    .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .reset_n(reset_n),
    .rdy_busy_n(rdy_busy_n), .last_cmd(last_cmd), .cmd_valid(cmd_valid),
    .rsv_nonzero(rsv_nonzero));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // cycles until ready (rdy) or a command pulse; an exhausted bound ends the run
  task automatic wait_for(logic rdy, int lim, output int c);
    c = 0;
    while ((rdy ? rdy_busy_n : cmd_valid) !== 1'b1) begin
      @(negedge clock);
      c++;
      if (c > lim) begin
        chk("wait bound", 1, 0);
        end_sim;
      end
    end
  endtask
  task automatic watch(int n, output int s);
    s = 0;
    repeat (n) begin
      @(negedge clock);
      s += (cmd_valid === 1'b1);
    end
  endtask
  // ==========
  // scenarios
  task automatic t_op(logic [7:0] op, logic hi, int n, logic [3:0] rs);
    int c;
    u_host.xfer({op, rs, 11'h5a3, 9'h0}, 32, hi);
    wait_for(1'b0, 50, c);
    chk("opcode", op, last_cmd.opcode);
    chk("page", 11'h5a3, last_cmd.page);
    chk("mode", hi, last_cmd.mode);
    chk("rsv", |rs, rsv_nonzero);
    chk("reserved", rs, last_cmd.reserved);
    wait_for(1'b1, n + 5, c);
    chk("busy", n, c);
    $display("test op %h done", op);
  endtask
  // frames one bit short or long are refused
  task automatic t_len;
    int s;
    for (int n = 31; n <= 33; n += 2) begin
      u_host.xfer(32'h5300_0000, n, 1'b0);
      watch(60, s);
      chk("odd frame", 0, s);
      chk("ready", 1, rdy_busy_n);
    end
    $display("test frame length done");
  endtask
  // a frame while busy is ignored; the reset pin then aborts
  task automatic t_abort;
    int s;
    u_host.xfer(32'h8300_0000, 32, 1'b1);
    wait_for(1'b0, 50, s);
    u_host.xfer(32'h5300_0000, 32, 1'b0);
    watch(60, s);
    chk("frame while busy", 0, s);
    chk("still busy", 0, rdy_busy_n);
    reset_n <= 1'b0; // chip select is high here
    watch(10, s); // well before the cut erase time would run out
    chk("ready in reset", 1, rdy_busy_n);
    watch(2490, s);
    reset_n <= 1'b1;
    watch(250, s);
    $display("test abort done");
  endtask
  initial begin
    rst_n = 1'b0;
    reset_n = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (20) @(negedge clock); // power-up wait, scaled down
    for (int i = 0; i < 8; i++) t_op(OPS[i], i[0], (i < 4) ? XC : EC, 4'h0);
    t_op(8'h55, 1'b1, XC, 4'ha);
    t_len;
    t_abort;
    t_op(8'h61, 1'b0, XC, 4'h0);
    end_sim;
  end
endmodule
